// ==== pin_far_side.sv ====
// board side of the pins: pull resistors and external drivers
`timescale 1ns/100ps
module pin_far_side
(
    // design drive
    input  wire reset_strap_pkg::gio_drive_type i_gio_drive,
    input  wire logic                           i_irq_out,
    input  wire logic                           i_irq_oe,
    // external drivers on the general I/O pins
    input  wire logic [5:0]                     i_ext_en,
    input  wire logic [5:0]                     i_ext_val,
    // resolved pin levels
    output logic [5:0]                          o_gio_in,
    output logic                                o_irq_line
);
    import reset_strap_pkg::*;
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // design wins, then board driver, else 1 M pull-down
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            o_gio_in[i] = i_gio_drive.oe[i] ? i_gio_drive.out[i]
                        : (i_ext_en[i] ? i_ext_val[i] : 1'b0);
        end
    end
    assign o_irq_line = i_irq_oe ? i_irq_out : 1'b1;
endmodule

// ==== reset_strap_ctrl.sv ====
// reset output, hard reset reload, interrupt pin, straps and general I/O states
`timescale 1ns/100ps
module reset_strap_ctrl
(
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    // supply and reset inputs
    input  wire logic                          i_switched_3v3_rail,
    input  wire logic                          i_manual_reset_in,
    input  wire logic                          i_manual_reset_active_low,
    input  wire logic                          i_hard_reset_in,
    // interrupt request from the core
    input  wire logic                          i_irq_request,
    // straps, already converted to levels
    input  wire logic                          i_bus_power_strap,
    input  wire logic [reset_strap_pkg::STRAP_W-1:0] i_address_strap,
    // hot-plug-detect configuration
    input  wire logic                          i_dp_mode_supported,
    input  wire reset_strap_pkg::hpd_mode_type i_hpd4_mode,
    input  wire logic                          i_hpd5_rx_enable,
    input  wire logic                          i_hpd_tx_level,
    // general I/O 3..8 pin side
    input  wire logic [reset_strap_pkg::GIO_COUNT-1:0] i_gio_in,
    output reset_strap_pkg::gio_drive_type     o_gio_drive,
    // reset and interrupt pins
    output logic                               o_system_reset_out_n,
    output logic                               o_host_interrupt_n_out,
    output logic                               o_host_interrupt_n_oe,
    // boot results and hot-plug-detect receive
    output reset_strap_pkg::strap_result_type  o_strap,
    output logic                               o_flash_reload,
    output logic                               o_hpd4_rx,
    output logic                               o_hpd5_rx
);
    import reset_strap_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] man_sync_reg;     // manual reset synchroniser
    logic [SYNC_STAGES-1:0] hard_sync_reg;    // hard reset synchroniser
    logic                   manual_active;    // selected level present
    logic                   hard_active;      // hard reset present
    seq_state_type          state_reg;        // boot sequence state
    seq_state_type          state_next;
    logic                   rst_out_n_reg;    // reset pin level
    logic                   irq_oe_reg;       // interrupt pull-down
    strap_result_type       strap_reg;        // captured straps
    logic                   reload_reg;       // flash reload pulse
    gio_drive_type          gio_reg;          // general I/O drive
    logic                   hpd4_rx_reg;      // received hpd on I/O 4
    logic                   hpd5_rx_reg;      // received hpd on I/O 5

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // first stage feeds only the second stage
    // two-stage synchronise
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            man_sync_reg  <= '0;
            hard_sync_reg <= '0;
        end
        else
        begin
            man_sync_reg  <= {man_sync_reg[SYNC_STAGES-2:0], i_manual_reset_in};
            hard_sync_reg <= {hard_sync_reg[SYNC_STAGES-2:0], i_hard_reset_in};
        end
    end

    assign manual_active = man_sync_reg[SYNC_STAGES-1] ^ i_manual_reset_active_low;
    assign hard_active   = hard_sync_reg[SYNC_STAGES-1];

    // ------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------
    // next state; hard reset overrides any state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_BOOT:   state_next = ST_RUN;     // straps sampled here
            ST_RUN:    state_next = ST_RUN;
            ST_HARD:   if (!hard_active) state_next = ST_RELOAD;
            ST_RELOAD: state_next = ST_BOOT;    // then resample straps
        endcase
        if (hard_active)
            state_next = ST_HARD;
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            state_reg <= ST_BOOT;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            reload_reg <= 1'b0;
        else
            reload_reg <= (state_reg == ST_HARD) && !hard_active;
    end

    // ------------------------------------------------------------
    // system reset output
    // ------------------------------------------------------------
    // low at reset; low for rail, manual level or sequence not running
    // reset drive
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            rst_out_n_reg <= 1'b0;
        else
            rst_out_n_reg <= i_switched_3v3_rail && !manual_active
                             && (state_reg == ST_RUN);
    end

    // ------------------------------------------------------------
    // host interrupt, open drain
    // ------------------------------------------------------------
    // pull low only
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_oe_reg <= 1'b0;
        else
            irq_oe_reg <= i_irq_request;
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // captured in the boot state, after reset release
    // sample straps
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            strap_reg.pp_disable <= PP_DISABLE_RESET;
            strap_reg.fw_master  <= 1'b0;
            strap_reg.addr       <= ADDR_TABLE[0];
        end
        else if (state_reg == ST_BOOT)
        begin
            strap_reg.pp_disable <= i_bus_power_strap;
            strap_reg.fw_master  <= (i_address_strap >= MASTER_MIN_CODE);
            strap_reg.addr       <= ADDR_TABLE[i_address_strap];
        end
    end

    // ------------------------------------------------------------
    // general I/O drive and hot-plug-detect
    // ------------------------------------------------------------
    // power-on states, overlaid by hpd roles when enabled
    always_ff @(posedge i_clk)
    begin
        // power-on states, also the idle base
        gio_reg.oe  <= GIO_POR_OE;
        gio_reg.out <= GIO_POR_OUT;
        // hpd pin roles, held off in reset
        if (!i_sys_rst && i_dp_mode_supported)
        begin
            unique case (i_hpd4_mode)
                // input only, line left to the board
                HPD_OFF, HPD_RX: gio_reg.oe[GIO4_IDX] <= 1'b0;
                HPD_TX:
                begin
                    gio_reg.oe[GIO4_IDX]  <= 1'b1;
                    gio_reg.out[GIO4_IDX] <= i_hpd_tx_level;
                end
                // shared line: pull low only
                HPD_TXRX: gio_reg.oe[GIO4_IDX] <= !i_hpd_tx_level;
            endcase
            if (i_hpd5_rx_enable)
                gio_reg.oe[GIO5_IDX] <= 1'b0;
        end
    end

    // hpd receive levels, zero when role not selected
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            hpd4_rx_reg <= 1'b0;
            hpd5_rx_reg <= 1'b0;
        end
        else
        begin
            hpd4_rx_reg <= i_dp_mode_supported && i_gio_in[GIO4_IDX]
                           && (i_hpd4_mode == HPD_RX || i_hpd4_mode == HPD_TXRX);
            hpd5_rx_reg <= i_dp_mode_supported && i_hpd5_rx_enable
                           && i_gio_in[GIO5_IDX];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_system_reset_out_n  = rst_out_n_reg;
    assign o_host_interrupt_n_out = 1'b0;
    assign o_host_interrupt_n_oe = irq_oe_reg;
    assign o_strap               = strap_reg;
    assign o_flash_reload        = reload_reg;
    assign o_gio_drive           = gio_reg;
    assign o_hpd4_rx             = hpd4_rx_reg;
    assign o_hpd5_rx             = hpd5_rx_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // boot captures are only looked for once reset was sampled low
    property p_rail_low;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_switched_3v3_rail |=> !o_system_reset_out_n;
    endproperty
    a_rail_low: assert property (p_rail_low) else $error("reset out high, rail low");
    property p_startup_low;
        @(posedge i_clk)
        i_sys_rst |=> !o_system_reset_out_n ##1 !o_system_reset_out_n;
    endproperty
    a_startup_low: assert property (p_startup_low) else $error("reset out high early");
    property p_manual_high;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_manual_reset_active_low && i_manual_reset_in)[*3]
        |=> !o_system_reset_out_n;
    endproperty
    a_manual_high: assert property (p_manual_high) else $error("manual high no reset");
    property p_manual_low;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_manual_reset_active_low && !i_manual_reset_in)[*3]
        |=> !o_system_reset_out_n;
    endproperty
    a_manual_low: assert property (p_manual_low) else $error("manual low no reset");
    property p_hard_reload;
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(hard_active) && state_reg == ST_HARD |=> o_flash_reload ##1 !o_flash_reload;
    endproperty
    a_hard_reload: assert property (p_hard_reload) else $error("no reload pulse");
    property p_irq_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_host_interrupt_n_oe == $past(i_irq_request)) && !o_host_interrupt_n_out;
    endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("interrupt pin wrong");
    property p_bus_strap;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst && state_reg == ST_BOOT |=> o_strap.pp_disable == $past(i_bus_power_strap);
    endproperty
    a_bus_strap: assert property (p_bus_strap) else $error("bus strap not taken");
    property p_por_pins;
        @(posedge i_clk)
        i_sys_rst |=> o_gio_drive.oe == GIO_POR_OE && o_gio_drive.out == GIO_POR_OUT;
    endproperty
    a_por_pins: assert property (p_por_pins) else $error("power-on pins wrong");
    property p_hpd5_rx;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_dp_mode_supported && i_hpd5_rx_enable |=> !o_gio_drive.oe[GIO5_IDX];
    endproperty
    a_hpd5_rx: assert property (p_hpd5_rx) else $error("hpd receive pin driven");
    property p_addr_strap;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_sys_rst && state_reg == ST_BOOT
        |=> o_strap.addr == ADDR_TABLE[$past(i_address_strap)];
    endproperty
    a_addr_strap: assert property (p_addr_strap) else $error("strap address wrong");
    property p_manual_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        manual_active |=> !o_system_reset_out_n;
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("reset out released");

endmodule

// ==== reset_strap_pkg.sv ====
// shared constants and types for the reset and pin strap control block
package reset_strap_pkg;

    // ------------------------------------------------------------
    // general I/O indices (bit position within the drive vectors)
    // ------------------------------------------------------------
    localparam int GIO_COUNT = 6;            // general I/O 3..8
    localparam int GIO3_IDX  = 0;
    localparam int GIO4_IDX  = 1;
    localparam int GIO5_IDX  = 2;
    localparam int GIO6_IDX  = 3;
    localparam int GIO7_IDX  = 4;
    localparam int GIO8_IDX  = 5;

    // ------------------------------------------------------------
    // power-on pin states
    // ------------------------------------------------------------
    // 3,4 inputs; 5,6,7 push-pull low; 8 open-drain released
    localparam logic [5:0] GIO_POR_OE  = 6'h1C;
    localparam logic [5:0] GIO_POR_OUT = 6'h00;

    // ------------------------------------------------------------
    // address strap decode
    // ------------------------------------------------------------
    localparam int STRAP_W = 2;              // quantised strap level code
    localparam int ADDR_W  = 7;              // two-wire bus address width
    // address per strap code; plain defaults, board dependent
    localparam logic [6:0] ADDR_TABLE [4] = '{7'h38, 7'h39, 7'h3A, 7'h3B};
    // strap codes at or above this make the part the firmware master
    localparam logic [1:0] MASTER_MIN_CODE = 2'h2;

    // ------------------------------------------------------------
    // reset values and synchroniser depth
    // ------------------------------------------------------------
    localparam int   SYNC_STAGES       = 2;
    localparam logic PP_DISABLE_RESET  = 1'b1;  // safe until strap sampled

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HPD_OFF, HPD_TX, HPD_RX, HPD_TXRX} hpd_mode_type;

    typedef enum {ST_BOOT, ST_RUN, ST_HARD, ST_RELOAD} seq_state_type;

    // one bank of driven pins: output level and output enable
    typedef struct packed {
        logic [GIO_COUNT-1:0] out;
        logic [GIO_COUNT-1:0] oe;
    } gio_drive_type;

    // boot strap results
    typedef struct packed {
        logic              pp_disable;   // high-voltage path held off
        logic              fw_master;    // master for shared firmware
        logic [ADDR_W-1:0] addr;         // address of both two-wire ports
    } strap_result_type;

endpackage

// ==== tb_reset_strap_ctrl.sv ====
// self-checking bench for the reset and pin strap control block
`timescale 1ns/100ps
module tb_reset_strap_ctrl;
    import reset_strap_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic             clk, rst, rail, man, man_lo, hard, irq, bp, dp, h5, tx;
    logic [1:0]       strap;
    hpd_mode_type     h4;
    logic [5:0]       ext_en, ext_val, gio_in;
    gio_drive_type    drv;
    strap_result_type sr;
    logic             rst_n, irq_out, irq_oe, irq_line, reload, rx4, rx5;
    int               n_errors, compares, cyc_cnt;

    reset_strap_ctrl u_reset_strap_ctrl (
        .i_clk(clk), .i_sys_rst(rst), .i_switched_3v3_rail(rail),
        .i_manual_reset_in(man), .i_manual_reset_active_low(man_lo),
        .i_hard_reset_in(hard), .i_irq_request(irq), .i_bus_power_strap(bp),
        .i_address_strap(strap), .i_dp_mode_supported(dp), .i_hpd4_mode(h4),
        .i_hpd5_rx_enable(h5), .i_hpd_tx_level(tx), .i_gio_in(gio_in),
        .o_gio_drive(drv), .o_system_reset_out_n(rst_n),
        .o_host_interrupt_n_out(irq_out), .o_host_interrupt_n_oe(irq_oe),
        .o_strap(sr), .o_flash_reload(reload), .o_hpd4_rx(rx4), .o_hpd5_rx(rx5));

    pin_far_side u_pin_far_side (
        .i_gio_drive(drv), .i_irq_out(irq_out), .i_irq_oe(irq_oe),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_gio_in(gio_in),
        .o_irq_line(irq_line));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000)
        begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    // wait n edges, then let updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // rail low forces reset
    task automatic t_rail();
        @(posedge clk) rail <= 1'h0;
        cyc(1);
        chk(rst_n, 1'h0, "rail low");
        cyc(5);
        chk(rst_n, 1'h0, "rail held");
        @(posedge clk) rail <= 1'h1;
        cyc(1);
        chk(rst_n, 1'h1, "rail up");
    endtask
    task automatic t_manual(input logic pol);
        @(posedge clk)
        begin
            man_lo <= pol;
            man    <= pol;
        end
        cyc(4);
        chk(rst_n, 1'h1, "manual idle");
        @(posedge clk) man <= ~pol;
        cyc(3);
        chk(rst_n, 1'h0, "manual on");
        cyc(20);
        chk(rst_n, 1'h0, "manual held");
        @(posedge clk) man <= pol;
        cyc(3);
        chk(rst_n, 1'h1, "manual off");
    endtask
    task automatic t_hard();
        @(posedge clk)
        begin
            hard  <= 1'h1;
            bp    <= 1'h0;
            strap <= 2'h1;
        end
        cyc(4);
        chk(rst_n, 1'h0, "hard on");
        cyc(10);
        chk(sr, {1'h1, 1'h1, 7'h3B}, "hold");
        @(posedge clk) hard <= 1'h0;
        cyc(2);
        chk(reload, 1'h0, "reload early");
        cyc(1);
        chk(reload, 1'h1, "reload");
        cyc(1);
        chk(reload, 1'h0, "reload pulse");
        // straps land in boot, reset out follows one edge later
        cyc(1);
        chk(sr, {1'h0, 1'h0, 7'h39}, "restrap");
        chk(rst_n, 1'h0, "boot still low");
        cyc(1);
        chk(rst_n, 1'h1, "hard exit");
    endtask
    task automatic t_irq();
        @(posedge clk) irq <= 1'h1;
        cyc(1);
        chk({irq_line, irq_oe}, 2'h1, "irq on");
        chk(irq_out, 1'h0, "irq level");
        @(posedge clk) irq <= 1'h0;
        cyc(1);
        chk({irq_line, irq_oe}, 2'h2, "irq off");
    endtask
    task automatic t_hpd();
        @(posedge clk)
        begin
            dp <= 1'h1;
            h4 <= HPD_TX;
            tx <= 1'h1;
        end
        cyc(2);
        chk({drv.oe[GIO4_IDX], drv.out[GIO4_IDX]}, 2'h3, "tx");
        @(posedge clk)
        begin
            h4      <= HPD_RX;
            h5      <= 1'h1;
            ext_en  <= 6'h06;
            ext_val <= 6'h06;
        end
        cyc(3);
        chk({drv.oe[GIO4_IDX], rx4, rx5}, 3'h3, "rx high");
        chk(drv.oe[GIO5_IDX], 1'h0, "rx5 released");
        @(posedge clk) ext_val <= 6'h00;
        cyc(3);
        chk({rx4, rx5}, 2'h0, "rx low");
        @(posedge clk)
        begin
            h4 <= HPD_TXRX;
            tx <= 1'h0;
        end
        cyc(2);
        chk({drv.oe[GIO4_IDX], drv.out[GIO4_IDX]}, 2'h2, "txrx low");
        @(posedge clk)
        begin
            h4      <= HPD_OFF;
            h5      <= 1'h0;
            dp      <= 1'h0;
            ext_val <= 6'h06;
        end
        cyc(3);
        chk({rx4, rx5}, 2'h0, "roles off");
        chk(drv, {GIO_POR_OUT, GIO_POR_OE}, "roles off pins");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, rail, bp, man, man_lo, hard, irq, dp, h5, tx} = 10'h380;
        strap    = 2'h3;
        h4       = HPD_OFF;
        ext_en   = 6'h00;
        ext_val  = 6'h00;
        n_errors = 0;
        compares = 0;
        cyc_cnt  = 0;
        cyc(5);
        chk(sr, {1'h1, 1'h0, 7'h38}, "strap in reset");
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        cyc(1);
        chk(rst_n, 1'h0, "start-up low");
        chk(drv, {6'h00, 6'h1C}, "power-on pins");
        chk(irq_line, 1'h1, "irq idle");
        cyc(4);
        chk(rst_n, 1'h1, "running");
        chk(sr, {1'h1, 1'h1, 7'h3B}, "boot strap");
        t_rail();
        t_manual(1'b0);
        t_manual(1'b1);
        t_hard();
        t_irq();
        t_hpd();
        results();
    end
endmodule
